// ==== verification/ecd_host_model.sv ====
// host scan model: hands the control image to the device once per scan
`timescale 1ns/1ps
`default_nettype none
module ecd_host_model
#(
  parameter int SCAN_CYCLES = 4
)
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [31:0] image,
  output logic             ctrl_valid,
  output logic [31:0]      host_control_image
);
  logic [7:0] scan_cnt;
  wire        scan_end = (scan_cnt == 8'(SCAN_CYCLES - 1));
  //////////////////////////////////////////////////////////////////////
  // scan counter; image and valid change together, so never torn
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      scan_cnt           <= 8'h00;
      ctrl_valid         <= 1'b0;
      host_control_image <= 32'h00000000;
    end
    else
    begin
      scan_cnt   <= scan_end ? 8'h00 : scan_cnt + 8'h01;
      ctrl_valid <= scan_end;
      if (scan_end)
        host_control_image <= image;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the encoder counter data and control layer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ecd_pkg::*;
;
  logic clock, resetn, quad, ctrl_valid, err_ev, cnt_up, cnt_dn, marker;
  logic home_sw, preload_in, total_load, error_flag, preload_latch;
  logic [31:0] image, ctrl_img, total_val;
  logic [15:0] err_code, gray_in, home_val, preload_val;
  logic [3:0]  strobe_in;
  logic [7:0]  output_enable, comp_lo;
  ecd_config_t        cfg;
  ecd_preset_t [15:0] presets;
  ecd_status_t        status;
  int error_cnt;
  int total_checks;
  //////////////////////////////////////////////////////////////////////
  // short ms tick keeps the timebase test to tens of cycles
  ecd_core #(.MS_CYCLES(10)) dut (
    .clock(clock), .resetn(resetn), .quadrature_counting_mode(quad),
    .cfg(cfg), .timebase_ms(16'h0001), .ctrl_valid(ctrl_valid),
    .host_control_image(ctrl_img), .error_event(err_ev),
    .error_code(err_code), .gray_in(gray_in), .count_up(cnt_up),
    .count_down(cnt_dn), .marker(marker), .home_switch(home_sw),
    .preload_input(preload_in), .home_value(home_val),
    .preload_value(preload_val), .total_load(total_load),
    .total_load_value(total_val), .strobe_in(strobe_in),
    .comparator_lo(comp_lo), .upper_presets(presets), .status(status),
    .error_flag(error_flag), .output_enable(output_enable),
    .preload_latch(preload_latch));
  ecd_host_model #(.SCAN_CYCLES(4)) host (
    .clock(clock), .resetn(resetn), .image(image),
    .ctrl_valid(ctrl_valid), .host_control_image(ctrl_img));
  //////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    summarize();
  end
  //////////////////////////////////////////////////////////////////////
  // helpers; inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // two whole scans so the image is surely taken and acted on
  task automatic scan(input logic [31:0] img);
    image = img;
    tick(11);
  endtask
  task automatic raise_error(input logic [15:0] code);
    err_code = code;
    err_ev = 1'b1;
    tick(1);
    err_ev = 1'b0;
    tick(3);
  endtask
  task automatic pulse_strobe(input int ch);
    strobe_in[ch] = 1'b1;
    tick(3);
    strobe_in[ch] = 1'b0;
    tick(2);
  endtask
  function automatic logic [15:0] g2b(input logic [15:0] g);
    logic [15:0] b;
    for (int i = 0; i < 16; i++)
      b[i] = ^(g >> i);
    return b;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    resetn = 1'b0;
    {quad, err_ev, cnt_up, marker, home_sw, preload_in, total_load} = '0;
    cnt_dn = 1'b0;
    comp_lo = 8'h00;
    image = 32'h0;
    err_code = 16'h0;
    gray_in = 16'h0;
    home_val = 16'h0123;
    preload_val = 16'h0456;
    total_val = 32'h00012345;
    strobe_in = 4'h0;
    cfg = '0;
    cfg.strobe_rising = 4'hF;
    presets = '0;
    presets[0].off_preset = 16'hFFFF;
    tick(2);
    check({31'h0, status === '0}, 32'h1);
    resetn = 1'b1;
    // gray word, its binary and the upper comparators
    gray_in = 16'hB3C5;
    tick(3);
    check(status.raw_gray_position, 32'hB3C5);
    check(status.binary_position, g2b(16'hB3C5));
    check(status.upper_comparator_states, 32'h0001);
    $display("test gray done");
    // output enables, reserved bits 8 to 15 and 27 to 30 set in the first two scans
    scan(32'h7800FFFF);
    check(output_enable, 32'h0F);
    cfg.outputs_5_8_enabled = 1'b1;
    scan(32'h7800FFFF);
    check(output_enable, 32'hFF);
    scan(32'h00000000);
    check(output_enable, 32'h00);
    $display("test control done");
    // first error holds, clear lets a new one in
    raise_error(16'h0011);
    raise_error(16'h0022);
    check(error_flag, 32'h1);
    check(status.first_error_code, 32'h0011);
    scan(32'h80000000);
    check(error_flag, 32'h0);
    check(status.first_error_code, 32'h0000);
    raise_error(16'h0033);
    check(status.first_error_code, 32'h0033);
    scan(32'h00000000);
    $display("test error done");
    // quadrature counting: 40 counts at one per cycle
    quad = 1'b1;
    tick(2);
    cnt_up = 1'b1;
    tick(40);
    check(status.counts_per_interval, 32'd10);
    cnt_up = 1'b0;
    tick(3);
    check(status.binary_position, 32'd40);
    check(status.running_total_count, 32'd40);
    $display("test count done");
    // strobe capture, lockout and latch reset
    pulse_strobe(0);
    check(status.strobe_capture_values[0], 32'd40);
    cnt_up = 1'b1;
    tick(5);
    cnt_up = 1'b0;
    pulse_strobe(0);
    check(status.strobe_capture_values[0], 32'd40);
    pulse_strobe(3);
    check(status.strobe_capture_values[3], 32'd45);
    scan(32'h00100000);
    pulse_strobe(0);
    check(status.strobe_capture_values[0], 32'd45);
    scan(32'h00000000);
    $display("test strobe done");
    // interval timers; spacings make each interval whole 10-cycle ms windows
    cfg.strobe_cmp_gated = 4'h2;
    pulse_strobe(1);
    check(status.strobe_capture_values[1], 32'h0000);
    comp_lo = 8'h20;
    pulse_strobe(1);
    check(status.strobe_capture_values[1], 32'd45);
    tick(46);
    pulse_strobe(1);
    check(status.interval_timer_one, 32'd5);
    tick(8);
    pulse_strobe(3);
    check(status.interval_timer_two, 32'd10);
    $display("test timer done");
    // home marker, then faceplate preload, then host total load
    home_sw = 1'b1;
    scan(32'h01000000);
    marker = 1'b1;
    tick(1);
    marker = 1'b0;
    tick(3);
    check(status.binary_position, 32'h0123);
    check(status.running_total_count, 32'h0);
    preload_in = 1'b1;
    tick(1);
    preload_in = 1'b0;
    tick(3);
    check(status.binary_position, 32'h0456);
    check(status.running_total_count, 32'h0);
    check(preload_latch, 32'h1);
    total_load = 1'b1;
    tick(1);
    total_load = 1'b0;
    tick(3);
    check(status.running_total_count, 32'h00012345);
    // one down count moves the position back and still adds to the total
    cnt_dn = 1'b1;
    tick(1);
    cnt_dn = 1'b0;
    tick(3);
    check(status.binary_position, 32'h0455);
    check(status.running_total_count, 32'h00012346);
    $display("test home done");
    summarize();
  end
endmodule
`default_nettype wire

// ==== verilog/ecd_core.sv ====
// data reporting and control bit layer of the encoder counter module
`timescale 1ns/1ps
`default_nettype none
`include "ecd_map.svh"
module ecd_core
  import ecd_pkg::*;
#(
  parameter int MS_CYCLES = `ECD_MS_CYCLES
)
(
  input  wire logic                clock,
  input  wire logic                resetn,
  input  wire logic                quadrature_counting_mode,
  input  wire ecd_config_t         cfg,
  input  wire logic [15:0]         timebase_ms,
  input  wire logic                ctrl_valid,
  input  wire logic [31:0]         host_control_image,
  input  wire logic                error_event,
  input  wire logic [15:0]         error_code,
  input  wire logic [15:0]         gray_in,
  input  wire logic                count_up,
  input  wire logic                count_down,
  input  wire logic                marker,
  input  wire logic                home_switch,
  input  wire logic                preload_input,
  input  wire logic [15:0]         home_value,
  input  wire logic [15:0]         preload_value,
  input  wire logic                total_load,
  input  wire logic [31:0]         total_load_value,
  input  wire logic [3:0]          strobe_in,
  input  wire logic [7:0]          comparator_lo,
  input  wire ecd_preset_t [15:0]  upper_presets,
  output ecd_status_t              status,
  output logic                     error_flag,
  output logic [7:0]               output_enable,
  output logic                     preload_latch
);
  ///////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [15:0] gray2bin(input logic [15:0] g);
    logic [15:0] b;
    b = 16'h0000;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--)
      b[i] = b[i + 1] ^ g[i];
    return b;
  endfunction

  function automatic logic in_range(input logic [15:0] p,
                                    input ecd_preset_t s);
    // a pair with off below on wraps through zero
    if (s.on_preset <= s.off_preset)
      return (p >= s.on_preset) && (p < s.off_preset);
    return (p >= s.on_preset) || (p < s.off_preset);
  endfunction

  ///////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0]      ctrl;
  logic [15:0]      err_code;
  logic [15:0]      position;
  logic [31:0]      total;
  logic [15:0]      acc;
  logic [15:0]      cpi;
  logic [15:0]      tb_ms;
  logic [31:0]      ms_div;
  logic             home_pending;
  logic [1:0]       t_run;
  logic [1:0][15:0] t_cnt;
  logic [1:0][15:0] t_val;
  logic [15:0]      upper;
  logic [3:0][15:0] cap;
  logic [3:0]       latch;
  logic [3:0]       qual;
  logic [3:0]       fire;

  ///////////////////////////////////////////////////////////////////////////
  // decode of the control image; scan edges act once per turn-on
  wire [31:0] img_used   = host_control_image & `ECD_CTRL_USED_MASK;
  wire [31:0] scan_rise  = {32{ctrl_valid}} & img_used & ~ctrl;
  wire        clear_err  = scan_rise[`ECD_BIT_CLEAR_ERROR];
  wire        home_cmd   = scan_rise[`ECD_BIT_HOME]
                           & quadrature_counting_mode;
  wire        preload_cmd = scan_rise[`ECD_BIT_PRELOAD]
                            & quadrature_counting_mode;
  wire        preload_rst = ctrl[`ECD_BIT_PRELOAD_RST]
                            & quadrature_counting_mode;
  wire [3:0]  strobe_rst = ctrl[`ECD_BIT_STROBE_RST +: 4];
  wire        ms_tick    = (ms_div == 32'(MS_CYCLES - 1));
  wire        tb_end     = ms_tick && (tb_ms >= timebase_ms - 16'h0001);
  wire        home_hit   = home_pending & marker & home_switch
                           & quadrature_counting_mode;
  // the faceplate preload is locked out by its latch unless reset is held
  wire        face_load  = preload_input & quadrature_counting_mode
                           & (~preload_latch | preload_rst);
  wire        cnt_ev     = count_up ^ count_down;
  wire [15:0] bin_word   = quadrature_counting_mode ? position
                           : gray2bin(gray_in);
  wire [7:0]  out_mask   = {{4{cfg.outputs_5_8_enabled}}, 4'hF};
  wire [3:0]  gate_ok;
  wire [15:0] next_upper;
  wire [15:0] next_acc   = acc + {15'h0000, cnt_ev};
  wire [1:0]  t_start;
  wire [1:0]  t_stop;

  ///////////////////////////////////////////////////////////////////////////
  // strobe channels; comparators 5 to 8 gate channels 1 to 4
  for (genvar i = 0; i < 4; i++)
  begin : g_strobe
    assign gate_ok[i] = ~cfg.strobe_cmp_gated[i]
                        | comparator_lo[4 + i];
    ecd_strobe u_strobe (
      .clock       (clock),
      .resetn      (resetn),
      .level       (strobe_in[i]),
      .rising_sel  (cfg.strobe_rising[i]),
      .gate_ok     (gate_ok[i]),
      .latch_reset (strobe_rst[i]),
      .position    (bin_word),
      .captured    (cap[i]),
      .latched     (latch[i]),
      .qual_edge   (qual[i]),
      .fire        (fire[i])
    );
  end

  // comparators 17 to 32 from their presets alone
  for (genvar j = 0; j < 16; j++)
  begin : g_upper
    assign next_upper[j] = in_range(bin_word, upper_presets[j]);
  end

  // timer t starts on the even input, stops on the odd or itself
  for (genvar t = 0; t < 2; t++)
  begin : g_tsel
    assign t_start[t] = fire[2 * t + 1];
    assign t_stop[t]  = cfg.timer_two_input[t] ? qual[2 * t]
                        : qual[2 * t + 1];
  end

  ///////////////////////////////////////////////////////////////////////////
  // control image, outputs and first error
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ctrl          <= 32'h00000000;
      output_enable <= 8'h00;
      error_flag    <= 1'b0;
      err_code      <= 16'h0000;
    end
    else
    begin
      if (ctrl_valid)
        ctrl <= img_used;
      output_enable <= ctrl[`ECD_BIT_OUT_LO +: 8] & out_mask;
      // a new error in the clearing cycle still gets latched
      if (error_event && (!error_flag || clear_err))
      begin
        error_flag <= 1'b1;
        err_code   <= error_code;
      end
      else if (clear_err)
      begin
        error_flag <= 1'b0;
        err_code   <= 16'h0000;
      end
    end
  end

  // millisecond divider and timebase count
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      ms_div <= 32'h00000000;
      tb_ms  <= 16'h0000;
      acc    <= 16'h0000;
      cpi    <= 16'h0000;
    end
    else
    begin
      ms_div <= ms_tick ? 32'h00000000 : ms_div + 32'h00000001;
      if (tb_end)
      begin
        tb_ms <= 16'h0000;
        cpi   <= next_acc;
        acc   <= 16'h0000;
      end
      else
      begin
        tb_ms <= ms_tick ? tb_ms + 16'h0001 : tb_ms;
        acc   <= next_acc;
      end
    end
  end

  // position counter, home, preload and running total
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      position      <= 16'h0000;
      total         <= 32'h00000000;
      home_pending  <= 1'b0;
      preload_latch <= 1'b0;
    end
    else
    begin
      if (home_hit)
        position <= home_value;
      else if (preload_cmd || face_load)
        position <= preload_value;
      else if (cnt_ev)
        position <= count_up ? position + 16'h0001 : position - 16'h0001;
      if (home_cmd)
        home_pending <= 1'b1;
      else if (home_hit)
        home_pending <= 1'b0;
      // a held reset keeps the latch off and lets every preload act
      if (face_load && !preload_rst)
        preload_latch <= 1'b1;
      else if (preload_rst)
        preload_latch <= 1'b0;
      if (total_load)
        total <= total_load_value;
      else if (home_hit)
        total <= 32'h00000000;
      else if (cnt_ev)
        total <= total + 32'h00000001;
    end
  end

  // interval timers count whole milliseconds while running
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      t_run <= 2'b00;
      t_cnt <= '0;
      t_val <= '0;
    end
    else
    begin
      for (int t = 0; t < 2; t++)
      begin
        if (t_run[t] && t_stop[t])
        begin
          t_run[t] <= 1'b0;
          t_val[t] <= t_cnt[t];
        end
        else if (!t_run[t] && t_start[t])
        begin
          t_run[t] <= 1'b1;
          t_cnt[t] <= 16'h0000;
        end
        else if (t_run[t] && ms_tick && t_cnt[t] != 16'hFFFF)
          t_cnt[t] <= t_cnt[t] + 16'h0001;
      end
    end
  end

  // status image, registered so every word leaves from a flip-flop
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      status <= '0;
      upper  <= 16'h0000;
    end
    else
    begin
      upper                          <= next_upper;
      status.first_error_code        <= err_code;
      status.counts_per_interval     <= cpi;
      status.raw_gray_position       <= gray_in;
      status.binary_position         <= bin_word;
      status.running_total_count     <= total;
      status.strobe_capture_values   <= cap;
      status.interval_timer_one      <= t_val[0];
      status.interval_timer_two      <= t_val[1];
      status.upper_comparator_states <= upper;
    end
  end

  ///////////////////////////////////////////////////////////////////////////
  // checks
  property p_err_hold;
    @(posedge clock) disable iff (!resetn)
      error_flag && !clear_err |=> $stable(err_code);
  endproperty
  a_err_hold: assert property (p_err_hold)
    else $error("error code changed while pending");

  property p_err_clear;
    @(posedge clock) disable iff (!resetn)
      clear_err && !error_event |=> !error_flag && err_code == 16'h0000;
  endproperty
  a_err_clear: assert property (p_err_clear)
    else $error("error clear did not clear");

  property p_gray;
    @(posedge clock) disable iff (!resetn)
      1'b1 |=> status.raw_gray_position == $past(gray_in);
  endproperty
  a_gray: assert property (p_gray)
    else $error("gray word not live");

  property p_bin;
    @(posedge clock) disable iff (!resetn)
      !quadrature_counting_mode |->
        (bin_word ^ {1'b0, bin_word[15:1]}) == gray_in;
  endproperty
  a_bin: assert property (p_bin)
    else $error("gray decode wrong");

  property p_home_total;
    @(posedge clock) disable iff (!resetn)
      home_hit && !total_load |=> total == 32'h00000000;
  endproperty
  a_home_total: assert property (p_home_total)
    else $error("home did not clear total");

  property p_face_total;
    @(posedge clock) disable iff (!resetn)
      face_load && !total_load && !home_hit && !cnt_ev |=> $stable(total);
  endproperty
  a_face_total: assert property (p_face_total)
    else $error("faceplate preload moved total");

  property p_lockout;
    @(posedge clock) disable iff (!resetn)
      latch[0] && !strobe_rst[0] |=> $stable(cap[0]);
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("latched strobe captured again");

  // every channel, so the one the scenarios hold in reset is watched too
  property p_rst_hold;
    @(posedge clock) disable iff (!resetn)
      (strobe_rst != 4'h0) |=> (latch & $past(strobe_rst)) == 4'h0;
  endproperty
  a_rst_hold: assert property (p_rst_hold)
    else $error("strobe latch set under reset");

  property p_outen;
    @(posedge clock) disable iff (!resetn)
      !cfg.outputs_5_8_enabled |=> output_enable[7:4] == 4'h0;
  endproperty
  a_outen: assert property (p_outen)
    else $error("outputs 5 to 8 enabled without configuration");

  property p_abs_cmd;
    @(posedge clock) disable iff (!resetn)
      !quadrature_counting_mode |=> $stable(home_pending);
  endproperty
  a_abs_cmd: assert property (p_abs_cmd)
    else $error("home command acted outside quadrature mode");

  c_error: cover property (@(posedge clock) error_flag ##1 clear_err);
  c_timer: cover property (@(posedge clock) t_run[0] ##1 !t_run[0]);
  c_strobe: cover property (@(posedge clock) fire[3]);
  c_tb: cover property (@(posedge clock) tb_end && cpi != 16'h0000);
endmodule
`default_nettype wire

// ==== verilog/ecd_map.svh ====
// constants for the encoder counter data and control layer
// Notes on behaviour
// - only the first error is reported until the host clears it
// - counts in the last finished timebase interval are reported
// - absolute mode shows the live Gray input word
// - binary word is converted Gray, or the counter in quadrature mode
// - running total clears at reset and a host command can preload it
// - quadrature mode: home marker clears the running total
// - quadrature mode: faceplate preload leaves the running total alone
// - strobe captures binary position; inputs 9 to 12 feed channels 1 to 4
// - timer one times input 10 edges, or input 10 to input 9
// - timer one starts only with latch clear and comparator 6 if gated
// - gated input 9 stops timer one only with comparator 5 on
// - timer two times input 12 edges, or input 12 to input 11
// - timer two starts only with latch clear and comparator 8 if gated
// - gated input 11 stops timer two only with comparator 7 on
// - comparators 17 to 32 follow only their on and off presets
// - control bits 0 to 7 enable outputs; 4 to 7 need configuration
// - control bits 20 to 23 reset strobe latches 1 to 4
// - bits 24 to 26 home, preload latch reset, preload; quadrature only
// - 32-bit control image each scan, bit 31 clears error, rest ignored
// - a latched strobe channel captures no strobes until its latch is reset; its edges still stop timers
// - a held strobe reset keeps latch off and captures every strobe
// - turning the error clear bit on clears flag and code for new errors
`ifndef ECD_MAP_SVH
`define ECD_MAP_SVH
`define ECD_CLOCK_PERIOD_NS 20
`define ECD_MS_NS 1000000
`define ECD_MS_CYCLES (`ECD_MS_NS / `ECD_CLOCK_PERIOD_NS)
`define ECD_TIMEBASE_MS_DEFAULT 16'h03E8
`define ECD_BIT_OUT_LO 0
`define ECD_BIT_STROBE_RST 20
`define ECD_BIT_HOME 24
`define ECD_BIT_PRELOAD_RST 25
`define ECD_BIT_PRELOAD 26
`define ECD_BIT_CLEAR_ERROR 31
`define ECD_CTRL_USED_MASK 32'h87F000FF
`endif

// ==== verilog/ecd_pkg.sv ====
// types for the encoder counter data and control layer
package ecd_pkg;
  typedef struct packed {
    logic [15:0]      first_error_code;
    logic [15:0]      counts_per_interval;
    logic [15:0]      raw_gray_position;
    logic [15:0]      binary_position;
    logic [31:0]      running_total_count;
    logic [3:0][15:0] strobe_capture_values;
    logic [15:0]      interval_timer_one;
    logic [15:0]      interval_timer_two;
    logic [15:0]      upper_comparator_states;
  } ecd_status_t;
  typedef struct packed {
    logic [3:0] strobe_rising;
    logic [3:0] strobe_cmp_gated;
    logic [1:0] timer_two_input;
    logic       outputs_5_8_enabled;
  } ecd_config_t;
  typedef struct packed {
    logic [15:0] on_preset;
    logic [15:0] off_preset;
  } ecd_preset_t;
endpackage

// ==== verilog/ecd_strobe.sv ====
// one strobe channel: edge select, gating, latch and capture
`timescale 1ns/1ps
`default_nettype none
module ecd_strobe
  import ecd_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        level,
  input  wire logic        rising_sel,
  input  wire logic        gate_ok,
  input  wire logic        latch_reset,
  input  wire logic [15:0] position,
  output logic [15:0]      captured,
  output logic             latched,
  output wire logic        qual_edge,
  output wire logic        fire
);
  logic prev;
  ///////////////////////////////////////////////////////////////////////////
  // edge of the chosen polarity, gated by the comparator when configured
  assign qual_edge = (rising_sel ? (level & ~prev) : (~level & prev))
                     & gate_ok;
  // a set latch locks out capture unless the reset is held
  assign fire = qual_edge & (~latched | latch_reset);

  // latch and capture registers
  always_ff @(posedge clock)
  begin
    if (!resetn)
    begin
      prev     <= 1'b0;
      latched  <= 1'b0;
      captured <= 16'h0000;
    end
    else
    begin
      prev <= level;
      if (fire)
        captured <= position;
      if (latch_reset)
        latched <= 1'b0;
      else if (fire)
        latched <= 1'b1;
    end
  end
endmodule
`default_nettype wire
